// ### include/ctlu_pkg.sv
// Shared constants and carrier types for the cache tag and translation unit
package ctlu_pkg;
   localparam int IC_BYTES        = 16384;
   localparam int IC_LINE_BYTES   = 32;
   localparam int DC_BYTES        = 8192;
   localparam int DC_LINE_BYTES   = 16;
   localparam int TB_ENTRIES      = 32;
   localparam int MTB_ENTRIES     = 2;
   localparam int PA_BITS         = 32;
   localparam int PAGE_BITS       = 12;
   localparam int VPN_BITS        = 28;
   localparam int PFN_BITS        = PA_BITS - PAGE_BITS;
   localparam int IC_SETS         = IC_BYTES / IC_LINE_BYTES;
   localparam int DC_SETS         = DC_BYTES / DC_LINE_BYTES;
   localparam int IC_OFF_BITS     = $clog2(IC_LINE_BYTES);
   localparam int DC_OFF_BITS     = $clog2(DC_LINE_BYTES);
   localparam int IC_IDX_BITS     = $clog2(IC_SETS);
   localparam int DC_IDX_BITS     = $clog2(DC_SETS);
   localparam int TB_IDX_BITS     = $clog2(TB_ENTRIES);
   localparam int TAG_LOW_REG_STATE_POS = 7;
   localparam logic [1:0] STATE_INVALID = 2'h0;
   localparam logic [1:0] STATE_VALID   = 2'h3;
   localparam logic CHECK_ENABLE_VAL    = 1'h0;
   localparam logic CHECK_DISABLE_VAL   = 1'h1;
   localparam logic [4:0] CP0_PARITY_DIAG = 5'h1a;
   localparam logic [4:0] CP0_CACHE_ERROR = 5'h1b;
   localparam logic [1:0] ATTR_UNCACHED   = 2'h2;
   localparam logic [1:0] ATTR_CACHED     = 2'h3;

   // Cache operations that reach this block
   typedef enum logic [2:0] {
      CTLU_OP_NONE      = 3'h0,
      CTLU_OP_LOAD_TAG  = 3'h1,
      CTLU_OP_STORE_TAG = 3'h3,
      CTLU_OP_HIT_WB    = 3'h2
   } ctlu_op_type;

   // Translation buffer software commands
   typedef enum logic [1:0] {
      CTLU_TB_NONE  = 2'h0,
      CTLU_TB_READ  = 2'h1,
      CTLU_TB_WRIDX = 2'h3,
      CTLU_TB_WRRND = 2'h2
   } ctlu_tbcmd_type;

   // One joint buffer entry: one tag, even and odd frames
   typedef struct packed {
      logic [VPN_BITS-1:0] vpn2;
      logic                valid_even;
      logic                valid_odd;
      logic [PFN_BITS-1:0] pfn_even;
      logic [PFN_BITS-1:0] pfn_odd;
      logic [1:0]          attr;
   } ctlu_entry_type;

   // Result of a translation
   typedef struct packed {
      logic                hit;
      logic                invalid;
      logic                cached;
      logic [PFN_BITS-1:0] pfn;
   } ctlu_xlat_type;
endpackage : ctlu_pkg

// ### core/ctlu_top.sv
// Cache tags, line state, joint and micro translation buffers
// Functional notes
// (R1) Instruction cache: 16 KB direct mapped, virtually indexed, 32-byte lines.
// (R2) Data cache: 8 KB direct mapped, virtually indexed, 16-byte lines.
// (R3) One data line state bit, copied to both state bits on tag load.
// (R4) Reported line state is only 00 invalid or 11 filled.
// (R5) Tag store loads tag-low bit 7 into state; software writes 00 or 11.
// (R6) Joint buffer: 32 fully associative entries, even and odd frames each.
// (R7) Software buffer ops during instruction miss stall never cause bogus invalid.
// (R8) Only uncached and cacheable attributes; two kernel physical regions valid.
// (R9) Physical addresses and cache tags are 32 bits wide; the tag arrays hold only the 20 address bits 31:12.
// (R10) No parity generated or checked on caches.
// (R11) Cache error register 27 not implemented; reads undefined.
// (R12) Parity diagnostic register 26 has no effect on cache behaviour.
// (R13) Never raise a cache parity error exception.
// (R14) Check-enable reads 0, check-disable reads 1, both hardwired.
// (R15) Hit write-back clears data line dirty indication.
// (R16) Fetches use two-entry micro buffer first, joint buffer on miss.
// (R17) Multiple joint matches keep running but set the shutdown flag.
// (R18) Hit needs valid state and stored tag equal translated upper bits.
// (R19) Index with low virtual bits above line offset, no replacement choice.
module ctlu_top
   import ctlu_pkg::*;
#(
   parameter int TB_N = TB_ENTRIES
) (
   input  wire logic                   clk_in,            // Processor clock
   input  wire logic                   rst_n_in,          // Sync reset, low
   input  wire logic                   ifetch_in,         // Fetch request
   input  wire logic [39:0]            ifetch_va_in,      // Fetch virtual address
   input  wire logic                   dacc_in,           // Data access request
   input  wire logic [39:0]            dacc_va_in,        // Data virtual address
   input  wire logic                   dfill_in,          // Data line filled by miss
   input  wire logic                   dstore_in,         // Store hit makes line dirty
   input  wire logic                   ifill_in,          // Instruction line filled
   input  wire ctlu_op_type            cop_in,            // Data cache operation
   input  wire logic [31:0]            tag_low_wr_in,     // Tag-low value for store tag
   input  wire ctlu_tbcmd_type         tbcmd_in,          // Buffer software command
   input  wire logic [TB_IDX_BITS-1:0] tb_index_in,       // Indexed entry
   input  wire logic [TB_IDX_BITS-1:0] tb_random_in,      // Random entry
   input  wire ctlu_entry_type         tb_wdata_in,       // Entry to write
   input  wire logic                   parity_diag_we_in, // Diagnostic reg write
   input  wire logic [7:0]             parity_diag_in,    // Diagnostic reg data
   output logic                        ihit_out,          // Fetch hit
   output logic                        imiss_stall_out,   // Instruction translation miss
   output ctlu_xlat_type               ixlat_out,         // Fetch translation
   output logic                        dhit_out,          // Data hit
   output logic                        ddirty_out,        // Data line dirty
   output ctlu_xlat_type               dxlat_out,         // Data translation
   output logic [31:0]                 tag_low_reg,       // Tag-low after load tag
   output ctlu_entry_type              tb_rdata_out,      // Buffer read result
   output logic                        shutdown_flag,     // Multiple match seen
   output logic                        check_enable_out,  // Parity check enable bit
   output logic                        check_disable_bit, // Parity check disable bit
   output logic [7:0]                  parity_diag_reg,   // Diagnostic register
   output logic                        parity_exc_out     // Parity exception, never
);
   // Tag arrays: one state bit per data line, physical tags
   logic [PFN_BITS-1:0] itag [IC_SETS];
   logic                ival [IC_SETS];
   logic [PFN_BITS-1:0] dtag [DC_SETS];
   logic                dval [DC_SETS];
   logic                ddty [DC_SETS];
   ctlu_entry_type      tb   [TB_N];
   ctlu_entry_type      mtb  [MTB_ENTRIES];
   logic                mtb_ok [MTB_ENTRIES];
   logic                mtb_lru;

   // Translate one address against one joint buffer entry
   function automatic ctlu_xlat_type tb_look(input logic [39:0] va,
                                             input ctlu_entry_type e);
      ctlu_xlat_type r;
      logic          v;
      r = '0;
      v = va[PAGE_BITS] ? e.valid_odd : e.valid_even;
      r.hit     = (e.vpn2 == VPN_BITS'(va[39:PAGE_BITS+1]));
      // (R8) only two attributes
      r.cached  = (e.attr == ATTR_CACHED);
      r.invalid = r.hit && !v;
      r.pfn     = va[PAGE_BITS] ? e.pfn_odd : e.pfn_even;
      return r;
   endfunction : tb_look

   // Kernel physical segment: unmapped, two regions by attribute
   function automatic ctlu_xlat_type kseg(input logic [39:0] va);
      ctlu_xlat_type r;
      r = '0;
      // (R8) two valid regions
      r.hit    = (va[39:30] == 10'h3fe) && (va[29] == 1'h0);
      r.cached = (va[28] == 1'h0);
      r.pfn    = va[PA_BITS-1:PAGE_BITS] & {3'h0, {(PFN_BITS-3){1'h1}}};
      return r;
   endfunction : kseg

   ctlu_xlat_type          ix_j, dx, ix_m, ix;
   logic [TB_IDX_BITS:0]   dmatch, imatch;
   logic                   mhit;
   logic                   dkseg, ikseg;
   logic [0:0]             mslot;

   // Combined lookups for data and fetch addresses
   always_comb begin
      ctlu_xlat_type t;
      t      = '0;
      dx     = kseg(dacc_va_in);
      ix_j   = kseg(ifetch_va_in);
      dkseg  = dx.hit;
      ikseg  = ix_j.hit;
      dmatch = '0;
      imatch = '0;
      // (R6) fully associative search; every match is counted, the first is used
      for (int k = 0; k < TB_N; k++) begin
         t = tb_look(dacc_va_in, tb[k]);
         if (t.hit && !dkseg) begin
            if (dmatch == '0) dx = t;
            dmatch = dmatch + 1'h1;
         end
         t = tb_look(ifetch_va_in, tb[k]);
         if (t.hit && !ikseg) begin
            if (imatch == '0) ix_j = t;
            imatch = imatch + 1'h1;
         end
      end
      // (R16) micro buffer looked up first
      mhit  = 1'h0;
      mslot = 1'h0;
      ix_m  = '0;
      for (int m = 0; m < MTB_ENTRIES; m++) begin
         t = tb_look(ifetch_va_in, mtb[m]);
         if (mtb_ok[m] && t.hit && !t.invalid && !mhit) begin
            mhit  = 1'h1;
            mslot = m[0:0];
            ix_m  = t;
         end
      end
      ix = mhit ? ix_m : ix_j;
   end

   // Cache index and tag compare
   logic [IC_IDX_BITS-1:0] iidx;
   logic [DC_IDX_BITS-1:0] didx;
   logic                   ihit_c, dhit_c;
   always_comb begin
      // (R19) index above line offset
      iidx = ifetch_va_in[IC_OFF_BITS +: IC_IDX_BITS];
      didx = dacc_va_in[DC_OFF_BITS +: DC_IDX_BITS];
      // (R18) valid and tag equal
      ihit_c = ival[iidx] && (itag[iidx] == ix.pfn) && ix.hit && ix.cached;
      dhit_c = dval[didx] && (dtag[didx] == dx.pfn) && dx.hit && dx.cached;
   end

   // Fetch stalls on a micro miss while the joint buffer refills it
   logic next_stall;
   always_comb begin
      next_stall = ifetch_in && !mhit && !ikseg;
   end

   // Register everything, including the arrays
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ihit_out          <= 1'h0;
         imiss_stall_out   <= 1'h0;
         ixlat_out         <= '0;
         dhit_out          <= 1'h0;
         ddirty_out        <= 1'h0;
         dxlat_out         <= '0;
         tag_low_reg       <= '0;
         tb_rdata_out      <= '0;
         shutdown_flag     <= 1'h0;
         parity_diag_reg   <= '0;
         check_enable_out  <= CHECK_ENABLE_VAL;
         check_disable_bit <= CHECK_DISABLE_VAL;
         parity_exc_out    <= 1'h0;
         mtb_lru           <= 1'h0;
         for (int m = 0; m < MTB_ENTRIES; m++) mtb_ok[m] <= 1'h0;
         for (int i = 0; i < IC_SETS; i++) ival[i] <= 1'h0;
         for (int i = 0; i < DC_SETS; i++) begin
            dval[i] <= 1'h0;
            ddty[i] <= 1'h0;
         end
      end else begin
         // (R11) no cache error register is built, nothing decodes it
         // (R14) hardwired parity bits
         check_enable_out  <= CHECK_ENABLE_VAL;
         check_disable_bit <= CHECK_DISABLE_VAL;
         // (R13) no parity exception ever
         parity_exc_out    <= 1'h0;
         // (R12) diagnostic only, read by nothing else
         if (parity_diag_we_in) parity_diag_reg <= parity_diag_in;
         ihit_out        <= ifetch_in && ihit_c;
         imiss_stall_out <= next_stall;
         ixlat_out       <= ix;
         dhit_out        <= dacc_in && dhit_c;
         ddirty_out      <= ddty[didx];
         dxlat_out       <= dx;
         // (R17) flag only, keep running
         if ((dacc_in && dmatch > 1) || (ifetch_in && imatch > 1)) shutdown_flag <= 1'h1;
         // (R16) refill micro buffer from the joint entry
         if (next_stall && ix_j.hit && !ix_j.invalid) begin
            mtb[mtb_lru].vpn2       <= VPN_BITS'(ifetch_va_in[39:PAGE_BITS+1]);
            // Only the fetched half is known here, so the other half stays invalid
            mtb[mtb_lru].valid_even <= !ifetch_va_in[PAGE_BITS];
            mtb[mtb_lru].valid_odd  <= ifetch_va_in[PAGE_BITS];
            mtb[mtb_lru].pfn_even   <= ix_j.pfn;
            mtb[mtb_lru].pfn_odd    <= ix_j.pfn;
            mtb[mtb_lru].attr       <= ix_j.cached ? ATTR_CACHED : ATTR_UNCACHED;
            mtb_ok[mtb_lru]         <= 1'h1;
            mtb_lru                 <= ~mtb_lru;
         end else if (mhit) begin
            mtb_lru <= ~mslot[0];
         end
         // (R7) software ops use their own port, flush micro buffer on write
         case (tbcmd_in)
            CTLU_TB_READ:  tb_rdata_out <= tb[tb_index_in];
            CTLU_TB_WRIDX: begin
               tb[tb_index_in] <= tb_wdata_in;
               for (int m = 0; m < MTB_ENTRIES; m++) mtb_ok[m] <= 1'h0;
            end
            CTLU_TB_WRRND: begin
               tb[tb_random_in] <= tb_wdata_in;
               for (int m = 0; m < MTB_ENTRIES; m++) mtb_ok[m] <= 1'h0;
            end
            default: ;
         endcase
         // (R1) instruction fill, physical tag (R9)
         if (ifill_in) begin
            ival[iidx] <= 1'h1;
            itag[iidx] <= ix.pfn;
         end
         // (R2) data fill sets state bit, no parity stored (R10)
         if (dfill_in) begin
            dval[didx] <= 1'h1;
            ddty[didx] <= 1'h0;
            dtag[didx] <= dx.pfn;
         end else if (dstore_in && dhit_c) begin
            ddty[didx] <= 1'h1;
         end
         case (cop_in)
            CTLU_OP_LOAD_TAG: begin
               // (R3) (R4) state bit copied twice
               tag_low_reg <= {dtag[didx], {(12-TAG_LOW_REG_STATE_POS-1){1'h0}},
                               dval[didx] ? STATE_VALID : STATE_INVALID,
                               {(TAG_LOW_REG_STATE_POS-1){1'h0}}};
            end
            CTLU_OP_STORE_TAG: begin
               // (R5) bit 7 into state
               dval[didx] <= tag_low_wr_in[TAG_LOW_REG_STATE_POS];
               dtag[didx] <= tag_low_wr_in[PA_BITS-1:PAGE_BITS];
               ddty[didx] <= 1'h0;
            end
            CTLU_OP_HIT_WB: begin
               // (R15) clear dirty on hit
               if (dhit_c) ddty[didx] <= 1'h0;
            end
            default: ;
         endcase
      end
   end
endmodule : ctlu_top

// ### tb/ctlu_monitor.sv
// Port checker for the cache tag and translation unit
module ctlu_monitor
   import ctlu_pkg::*;
#(
   parameter int TB_N = TB_ENTRIES
) (
   input wire logic        clk_in,            // Clock
   input wire logic        rst_n_in,          // Sync reset, low
   input wire logic        dacc_in,           // Data access
   input wire logic [39:0] dacc_va_in,        // Data address
   input wire logic        dfill_in,          // Line fill
   input wire ctlu_op_type cop_in,            // Cache operation
   input wire logic [31:0] tag_low_wr_in,     // Store tag data
   input wire logic        parity_diag_we_in, // Diagnostic write
   input wire logic [7:0]  parity_diag_in,    // Diagnostic data
   input wire logic        dhit_out,          // Data hit
   input wire logic [31:0] tag_low_reg,       // Tag-low result
   input wire logic        shutdown_flag,     // Multiple match
   input wire logic        check_enable_out,  // Check enable bit
   input wire logic        check_disable_bit, // Check disable bit
   input wire logic [7:0]  parity_diag_reg,   // Diagnostic register
   input wire logic        parity_exc_out     // Parity exception
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking mon_cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   chk_enable_a: assert property (check_enable_out == CHECK_ENABLE_VAL)
      else $error("check enable bit not low");
   chk_disable_a: assert property (check_disable_bit == CHECK_DISABLE_VAL)
      else $error("check disable bit not high");
   parity_exc_a: assert property (!parity_exc_out)
      else $error("parity exception raised");
   // only two states, bits 11:8 zero
   state_code_a: assert property ((tag_low_reg[7:6] == STATE_INVALID ||
      tag_low_reg[7:6] == STATE_VALID) && tag_low_reg[11:8] == 4'h0)
      else $error("bad line state field");
   store_load_a: assert property ((cop_in == CTLU_OP_STORE_TAG) ##1
      (cop_in == CTLU_OP_LOAD_TAG && $stable(dacc_va_in)) |=>
      tag_low_reg[7:6] == {2{$past(tag_low_wr_in[7], 2)}})
      else $error("stored state not returned");
   shutdown_hold_a: assert property (shutdown_flag |=> shutdown_flag)
      else $error("shutdown flag dropped");
   diag_write_a: assert property (parity_diag_we_in |=>
      parity_diag_reg == $past(parity_diag_in))
      else $error("diagnostic register not written");
   fill_hit_a: assert property ((dfill_in && dacc_va_in[39:28] == 12'hff8) ##1
      (dacc_in && $stable(dacc_va_in) && cop_in == CTLU_OP_NONE) |=> dhit_out)
      else $error("no hit after fill");
endmodule : ctlu_monitor

bind ctlu_top ctlu_monitor #(.TB_N(TB_N)) ctlu_monitor_inst (.clk_in(clk_in),
   .rst_n_in(rst_n_in), .dacc_in(dacc_in), .dacc_va_in(dacc_va_in), .dfill_in(dfill_in),
   .cop_in(cop_in), .tag_low_wr_in(tag_low_wr_in), .parity_diag_we_in(parity_diag_we_in),
   .parity_diag_in(parity_diag_in), .dhit_out(dhit_out), .tag_low_reg(tag_low_reg),
   .shutdown_flag(shutdown_flag), .check_enable_out(check_enable_out),
   .check_disable_bit(check_disable_bit), .parity_diag_reg(parity_diag_reg),
   .parity_exc_out(parity_exc_out));

// ### tb/ctlu_partner.sv
// Fetch side pipeline model that holds a fetch through its miss stall
module ctlu_partner (
   input  wire logic        clk_in,       // Clock
   input  wire logic        rst_n_in,     // Sync reset, low
   input  wire logic        go_in,        // Start a fetch
   input  wire logic [39:0] va_in,        // Fetch address
   input  wire logic        stall_in,     // Miss stall
   output logic             ifetch_out,   // Fetch request
   output logic [39:0]      ifetch_va_out // Fetch address
);
   timeunit 1ns;
   timeprecision 1ns;
   logic g;
   logic in_reset;
   int   held;
   // Hold at least three cycles and while stalled; a released address shows its inverse
   // Idle address after reset is all ones, which no test entry maps
   // never touches the cache error register
   always @(posedge clk_in) begin
      g = go_in && rst_n_in;
      in_reset = !rst_n_in;
      #5;
      if (in_reset) begin
         ifetch_out = 1'h0;
         ifetch_va_out = '1;
         held = 0;
      end else if (g) begin
         ifetch_out = 1'h1;
         ifetch_va_out = va_in;
         held = 0;
      end else if (ifetch_out && (stall_in || held < 2)) begin
         held++;
      end else if (ifetch_out) begin
         ifetch_out = 1'h0;
         ifetch_va_out = ~ifetch_va_out;
      end
   end
endmodule : ctlu_partner

// ### tb/testbench.sv
// Self-checking bench for the cache tag and translation unit
module testbench
   import ctlu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 0, rst_n_in = 0, dacc_in = 0, dfill_in = 0, dstore_in = 0, go = 0;
   logic ifetch_in, imiss_stall_out, dhit_out, ddirty_out, shutdown_flag, we = 0, got;
   logic check_enable_out, check_disable_bit, parity_exc_out;
   logic ihit_out, ifill_in = 0;
   logic [39:0]    dacc_va_in = 0, ifetch_va_in, va;
   logic [31:0]    tag_low_wr_in = 0, tag_low_reg, w;
   logic [7:0]     parity_diag_in = 0, parity_diag_reg;
   logic [4:0]     tb_index_in = 0, tb_random_in = 0;
   logic [95:0]    r;
   ctlu_op_type    cop_in = CTLU_OP_NONE;
   ctlu_tbcmd_type tbcmd_in = CTLU_TB_NONE;
   ctlu_entry_type tb_wdata_in = '0, tb_rdata_out, e;
   ctlu_entry_type m_tb [TB_ENTRIES];
   ctlu_xlat_type  ixlat_out, dxlat_out;
   logic           m_st [DC_SETS];
   int             fails = 0, n_checks = 0, i, k, n_stall = 0, n_ihit = 0;

   ctlu_top ctlu_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ifetch_in(ifetch_in),
      .ifetch_va_in(ifetch_va_in), .dacc_in(dacc_in), .dacc_va_in(dacc_va_in),
      .dfill_in(dfill_in), .dstore_in(dstore_in), .ifill_in(ifill_in), .cop_in(cop_in),
      .tag_low_wr_in(tag_low_wr_in), .tbcmd_in(tbcmd_in), .tb_index_in(tb_index_in),
      .tb_random_in(tb_random_in), .tb_wdata_in(tb_wdata_in), .parity_diag_we_in(we),
      .parity_diag_in(parity_diag_in), .ihit_out(ihit_out), .imiss_stall_out(imiss_stall_out),
      .ixlat_out(ixlat_out), .dhit_out(dhit_out), .ddirty_out(ddirty_out),
      .dxlat_out(dxlat_out), .tag_low_reg(tag_low_reg), .tb_rdata_out(tb_rdata_out),
      .shutdown_flag(shutdown_flag), .check_enable_out(check_enable_out),
      .check_disable_bit(check_disable_bit), .parity_diag_reg(parity_diag_reg),
      .parity_exc_out(parity_exc_out));
   ctlu_partner ctlu_partner_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go),
      .va_in(40'h40), .stall_in(imiss_stall_out), .ifetch_out(ifetch_in),
      .ifetch_va_out(ifetch_va_in));

   // Free running clock
   always #50 clk_in = ~clk_in;

   // Inputs change 5 ns after the edge, results are read there too
   task cyc;
      @(posedge clk_in);
      #5;
   endtask : cyc
   task op(input logic a, f, s, input ctlu_op_type c, input logic [39:0] v,
           input ctlu_tbcmd_type t);
      dacc_in = a;
      dfill_in = f;
      dstore_in = s;
      cop_in = c;
      dacc_va_in = v;
      tbcmd_in = t;
      cyc;
   endtask : op
   task chk(input string n, input logic [63:0] x, input logic [63:0] g);
      n_checks++;
      if (g !== x) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task chke(input ctlu_entry_type x, input ctlu_entry_type g);
      n_checks++;
      if (g !== x) begin
         fails++;
         $display("wrong value entry expected %h seen %h", x, g);
      end
   endtask : chke
   task results;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results

   // Watchdog well beyond the 135 or so cycles the run needs
   initial begin
      #300000;
      fails++;
      results;
   end

   // Main sequence
   initial begin
      void'($urandom(51914));
      foreach (m_st[j]) m_st[j] = 1'h0;
      repeat (10) cyc;
      rst_n_in = 1'h1;
      chk("enable", CHECK_ENABLE_VAL, check_enable_out);
      chk("disable", CHECK_DISABLE_VAL, check_disable_bit);
      for (i = 0; i < 4; i++) begin
         va = {12'hff8, 28'($urandom())};
         op(0, 0, 0, CTLU_OP_LOAD_TAG, va, CTLU_TB_NONE);
         chk("state", {2{m_st[va[12:4]]}}, tag_low_reg[7:6]);
         w = $urandom();
         w[6] = w[7];
         tag_low_wr_in = w;
         op(0, 0, 0, CTLU_OP_STORE_TAG, va, CTLU_TB_NONE);
         op(0, 0, 0, CTLU_OP_LOAD_TAG, va, CTLU_TB_NONE);
         chk("tag low", {w[31:12], 4'h0, {2{w[7]}}, 6'h0}, tag_low_reg);
         op(1, 1, 0, CTLU_OP_NONE, va, CTLU_TB_NONE);
         m_st[va[12:4]] = 1'h1;
         op(1, 0, 1, CTLU_OP_NONE, va, CTLU_TB_NONE);
         chk("hit", 1'h1, dhit_out);
         chk("cached", 1'h1, dxlat_out.cached);
         op(1, 0, 0, CTLU_OP_NONE, va, CTLU_TB_NONE);
         chk("dirty", 1'h1, ddirty_out);
         op(0, 0, 0, CTLU_OP_HIT_WB, va, CTLU_TB_NONE);
         op(1, 0, 0, CTLU_OP_NONE, va ^ 40'h2000, CTLU_TB_NONE);
         chk("alias hit", 1'h0, dhit_out);
         op(1, 0, 0, CTLU_OP_NONE, va ^ 40'h10000000, CTLU_TB_NONE);
         chk("uncached", 2'h2, {dxlat_out.hit, dxlat_out.cached});
         op(1, 0, 0, CTLU_OP_LOAD_TAG, va, CTLU_TB_NONE);
         chk("clean", 1'h0, ddirty_out);
         chk("fill state", STATE_VALID, tag_low_reg[7:6]);
         tag_low_wr_in = 32'h0;
         op(0, 0, 0, CTLU_OP_STORE_TAG, va, CTLU_TB_NONE);
         op(1, 0, 0, CTLU_OP_NONE, va, CTLU_TB_NONE);
         m_st[va[12:4]] = 1'h0;
         chk("invalid hit", 1'h0, dhit_out);
      end
      parity_diag_in = 8'($urandom());
      we = 1'h1;
      op(1, 1, 0, CTLU_OP_NONE, va, CTLU_TB_NONE);
      we = 1'h0;
      op(1, 0, 0, CTLU_OP_NONE, va, CTLU_TB_NONE);
      chk("diag hit", 1'h1, dhit_out);
      chk("diag reg", parity_diag_in, parity_diag_reg);
      for (i = 0; i < 2 * TB_ENTRIES; i++) begin
         r = {$urandom(), $urandom(), $urandom()};
         e = r[71:0];
         e.vpn2 = 28'(i + 1);
         e.attr = ATTR_CACHED;
         tb_index_in = 5'(i);
         tb_wdata_in = e;
         if (i < TB_ENTRIES) m_tb[i] = e;
         op(0, 0, 0, CTLU_OP_NONE, va, i < TB_ENTRIES ? CTLU_TB_WRIDX : CTLU_TB_READ);
         if (i >= TB_ENTRIES) chke(m_tb[i - TB_ENTRIES], tb_rdata_out);
      end
      k = $urandom_range(0, TB_ENTRIES - 2);
      e.vpn2 = 28'h0;
      e.valid_even = 1'h1;
      tb_random_in = 5'(k);
      tb_wdata_in = e;
      m_tb[k] = e;
      op(0, 0, 0, CTLU_OP_NONE, va, CTLU_TB_WRRND);
      op(1, 0, 0, CTLU_OP_NONE, 40'h40, CTLU_TB_NONE);
      chk("pfn", e.pfn_even, dxlat_out.pfn);
      chk("no shutdown", 1'h0, shutdown_flag);
      go = 1'h1;
      got = 1'h0;
      // Fetch stands three edges: miss and refill, micro hit with fill, cache hit
      for (i = 0; i < 6; i++) begin
         tb_index_in = 5'(k + 1);
         ifill_in = (i == 2);
         op(0, 0, 0, CTLU_OP_NONE, va, CTLU_TB_READ);
         go = 1'h0;
         if (ixlat_out.hit === 1'h1 && ixlat_out.pfn === e.pfn_even) got = 1'h1;
         if (imiss_stall_out === 1'h1) n_stall++;
         if (ihit_out === 1'h1) n_ihit++;
         chk("bogus invalid", 1'h0, ixlat_out.invalid);
         chke(m_tb[k + 1], tb_rdata_out);
      end
      ifill_in = 1'h0;
      chk("fetch hit", 1'h1, got);
      chk("stall cycles", 1, n_stall);
      chk("fetch cache hits", 1, n_ihit);
      tb_index_in = 5'(k + 1);
      op(0, 0, 0, CTLU_OP_NONE, va, CTLU_TB_WRIDX);
      op(1, 0, 0, CTLU_OP_NONE, 40'h40, CTLU_TB_NONE);
      op(0, 0, 0, CTLU_OP_NONE, 40'h40, CTLU_TB_NONE);
      chk("shutdown", 2'h3, {shutdown_flag, dxlat_out.hit});
      chk("parity exception", 1'h0, parity_exc_out);
      results;
   end
endmodule : testbench
